// ---- core/nvsc_pkg.sv ----
`default_nettype none
package nvsc_pkg;
    // ----------------------------------------
    // bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int SEQ_LEN = 6;
    localparam int SEQ_CMP_W = 16;
    // ----------------------------------------
    // command sequence addresses
    // ----------------------------------------
    localparam logic [15:0] SEQ_A0 = 16'h4E38;
    localparam logic [15:0] SEQ_A1 = 16'hB1C7;
    localparam logic [15:0] SEQ_A2 = 16'h83E0;
    localparam logic [15:0] SEQ_A3 = 16'h7C1F;
    localparam logic [15:0] SEQ_A4 = 16'h703F;
    localparam logic [15:0] SEQ_STORE = 16'h8FC0;
    localparam logic [15:0] SEQ_RECALL = 16'h4C63;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 40000;
    localparam int STROBE_NS = 80;
    localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STORE_CYCLE_TIME_US = 12500;
    localparam int STORE_CYC = STORE_CYCLE_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int SOFT_RECALL_TIME_US = 40;
    localparam int RECALL_CYC = SOFT_RECALL_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int POWERUP_RECALL_TIME_US = 20000;
    localparam int PUP_RECALL_CYC = POWERUP_RECALL_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int STORE_GRACE_TIME_NS = 1000;
    localparam int GRACE_CYC = (STORE_GRACE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ----------------------------------------
    // host commands
    // ----------------------------------------
    typedef enum logic [2:0] {
        NVSC_CMD_READ,
        NVSC_CMD_WRITE,
        NVSC_CMD_SW_STORE,
        NVSC_CMD_SW_RECALL,
        NVSC_CMD_HW_STORE
    } nvsc_cmd_e;
endpackage
`default_nettype wire

// ---- core/nvsc_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvsc_timer #(
    parameter int CNT_W = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [CNT_W-1:0] count,
    output logic done
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic done_q;
    logic done_d;

    always_comb
    begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (load)
        begin
            cnt_d = count;
        end
        else if (cnt_q != '0)
        begin
            cnt_d = cnt_q - 1'b1;
            done_d = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
endmodule
`default_nettype wire

// ---- core/nvsc_host.sv ----
// Operation
// - write with select, strobe low; address stable
// - host keeps gate high throughout writes
// - six reads start software store
// - intervening access aborts sequence
// - sequence steps are reads, write high
// - six reads start software recall
`timescale 1ns/1ps
`default_nettype none
module nvsc_host #(
    parameter int STORE_CYC = nvsc_pkg::STORE_CYC,
    parameter int RECALL_CYC = nvsc_pkg::RECALL_CYC,
    parameter int PUP_RECALL_CYC = nvsc_pkg::PUP_RECALL_CYC,
    parameter int GRACE_CYC = nvsc_pkg::GRACE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire nvsc_pkg::nvsc_cmd_e cmd,
    input wire logic [nvsc_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [nvsc_pkg::DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [nvsc_pkg::DATA_W-1:0] rsp_rdata,
    output logic [nvsc_pkg::ADDR_W-1:0] address_lines,
    output logic [nvsc_pkg::DATA_W-1:0] data_lines_o,
    output logic data_lines_oe,
    input wire logic [nvsc_pkg::DATA_W-1:0] data_lines_i,
    output logic chip_sel_n,
    output logic out_gate_n,
    output logic wr_strobe_n,
    output logic nv_busy_req_n_o,
    output logic nv_busy_req_n_oe,
    input wire logic nv_busy_req_n_i
);
    localparam int TW = 20;
    typedef enum {
        ST_PUP, ST_IDLE, ST_SETUP, ST_STROBE, ST_END, ST_SEQ, ST_NVWAIT, ST_HWPULL, ST_BUSY
    } nvsc_state_e;

    function automatic logic [15:0] seq_addr(input logic [2:0] idx, input logic recall);
        case (idx)
            3'h0: seq_addr = nvsc_pkg::SEQ_A0;
            3'h1: seq_addr = nvsc_pkg::SEQ_A1;
            3'h2: seq_addr = nvsc_pkg::SEQ_A2;
            3'h3: seq_addr = nvsc_pkg::SEQ_A3;
            3'h4: seq_addr = nvsc_pkg::SEQ_A4;
            default: seq_addr = recall ? nvsc_pkg::SEQ_RECALL : nvsc_pkg::SEQ_STORE;
        endcase
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [nvsc_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;
    logic busy_s1_q, busy_s2_q;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            busy_s1_q <= 1'b1;
            busy_s2_q <= 1'b1;
        end
        else
        begin
            dq_s1_q <= data_lines_i;
            dq_s2_q <= dq_s1_q;
            busy_s1_q <= nv_busy_req_n_i;
            busy_s2_q <= busy_s1_q;
        end
    end

    // ----------------------------------------
    // host sequencer
    // ----------------------------------------
    nvsc_state_e st_q, st_d;
    logic [TW-1:0] wait_q, wait_d;
    logic [2:0] step_q, step_d;
    logic recall_q, recall_d, wr_q, wr_d, seq_q, seq_d;
    logic [nvsc_pkg::ADDR_W-1:0] addr_q, addr_d;
    logic [nvsc_pkg::DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic ce_q, ce_d, oe_q, oe_d, we_q, we_d, doe_q, doe_d, hpull_q, hpull_d;
    logic rdy_q, rdy_d, rv_q, rv_d;
    logic tload;
    logic [TW-1:0] tcount;
    logic tdone;

    nvsc_timer #(.CNT_W(TW)) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(tload),
        .count(tcount),
        .done(tdone)
    );

    always_comb
    begin
        st_d = st_q;
        wait_d = wait_q;
        step_d = step_q;
        recall_d = recall_q;
        wr_d = wr_q;
        seq_d = seq_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        ce_d = ce_q;
        oe_d = oe_q;
        we_d = we_q;
        doe_d = doe_q;
        hpull_d = hpull_q;
        rdy_d = 1'b0;
        rv_d = 1'b0;
        tload = 1'b0;
        tcount = '0;
        case (st_q)
            ST_PUP:
            begin
                tload = 1'b1;
                tcount = TW'(PUP_RECALL_CYC);
                st_d = ST_NVWAIT;
            end
            ST_IDLE:
            begin
                rdy_d = busy_s2_q;
                if (cmd_valid && rdy_q)
                begin
                    rdy_d = 1'b0;
                    addr_d = cmd_addr;
                    wdat_d = cmd_wdata;
                    wr_d = (cmd == nvsc_pkg::NVSC_CMD_WRITE);
                    recall_d = (cmd == nvsc_pkg::NVSC_CMD_SW_RECALL);
                    seq_d = 1'b0;
                    step_d = 3'h0;
                    case (cmd)
                        nvsc_pkg::NVSC_CMD_SW_STORE, nvsc_pkg::NVSC_CMD_SW_RECALL:
                        begin
                            seq_d = 1'b1;
                            wr_d = 1'b0;
                            st_d = ST_SEQ;
                        end
                        nvsc_pkg::NVSC_CMD_HW_STORE:
                        begin
                            hpull_d = 1'b1;
                            wait_d = TW'(GRACE_CYC);
                            st_d = ST_HWPULL;
                        end
                        default:
                            st_d = ST_SETUP;
                    endcase
                end
            end
            ST_SEQ:
            begin
                addr_d = {1'b0, seq_addr(step_q, recall_q)};
                st_d = ST_SETUP;
            end
            ST_SETUP:
            begin
                ce_d = 1'b0;
                oe_d = wr_q;
                we_d = ~wr_q;
                doe_d = wr_q;
                wait_d = TW'(nvsc_pkg::STROBE_CYC);
                st_d = ST_STROBE;
            end
            ST_STROBE:
            begin
                wait_d = wait_q - 1'b1;
                if (wait_q == TW'(1))
                begin
                    st_d = ST_END;
                end
            end
            ST_END:
            begin
                rdat_d = dq_s2_q;
                ce_d = 1'b1;
                oe_d = 1'b1;
                we_d = 1'b1;
                doe_d = 1'b0;
                if (!seq_q)
                begin
                    rv_d = 1'b1;
                    st_d = ST_IDLE;
                end
                else if (step_q == 3'(nvsc_pkg::SEQ_LEN - 1))
                begin
                    tload = 1'b1;
                    tcount = recall_q ? TW'(RECALL_CYC) : TW'(STORE_CYC);
                    st_d = ST_NVWAIT;
                end
                else
                begin
                    step_d = step_q + 3'h1;
                    st_d = ST_SEQ;
                end
            end
            ST_HWPULL:
            begin
                wait_d = wait_q - 1'b1;
                if (wait_q == TW'(1))
                begin
                    hpull_d = 1'b0;
                    st_d = ST_BUSY;
                end
            end
            ST_NVWAIT:
            begin
                if (tdone)
                begin
                    st_d = ST_BUSY;
                end
            end
            ST_BUSY:
            begin
                if (busy_s2_q)
                begin
                    rv_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_q <= ST_PUP;
            wait_q <= '0;
            step_q <= 3'h0;
            recall_q <= 1'b0;
            wr_q <= 1'b0;
            seq_q <= 1'b0;
            addr_q <= '0;
            wdat_q <= '0;
            rdat_q <= '0;
            ce_q <= 1'b1;
            oe_q <= 1'b1;
            we_q <= 1'b1;
            doe_q <= 1'b0;
            hpull_q <= 1'b0;
            rdy_q <= 1'b0;
            rv_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            wait_q <= wait_d;
            step_q <= step_d;
            recall_q <= recall_d;
            wr_q <= wr_d;
            seq_q <= seq_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            ce_q <= ce_d;
            oe_q <= oe_d;
            we_q <= we_d;
            doe_q <= doe_d;
            hpull_q <= hpull_d;
            rdy_q <= rdy_d;
            rv_q <= rv_d;
        end
    end

    assign cmd_ready = rdy_q;
    assign rsp_valid = rv_q;
    assign rsp_rdata = rdat_q;
    assign address_lines = addr_q;
    assign data_lines_o = wdat_q;
    assign data_lines_oe = doe_q;
    assign chip_sel_n = ce_q;
    assign out_gate_n = oe_q;
    assign wr_strobe_n = we_q;
    assign nv_busy_req_n_o = 1'b0;
    assign nv_busy_req_n_oe = hpull_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_write_gate_high;
        @(posedge ref_clk) disable iff (rst) (!we_q) |-> (oe_q && !ce_q && doe_q);
    endproperty
    a_write_gate_high: assert property (p_write_gate_high) else $error("gate low during write");

    property p_read_strobe;
        @(posedge ref_clk) disable iff (rst) (!ce_q && !oe_q) |-> (we_q && !doe_q);
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read with write strobe low");

    property p_addr_stable;
        @(posedge ref_clk) disable iff (rst) (!ce_q && $past(!ce_q)) |-> $stable(address_lines);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");

    property p_seq_upper;
        @(posedge ref_clk) disable iff (rst) (seq_q && !ce_q) |-> (address_lines[16] == 1'b0 && we_q);
    endproperty
    a_seq_upper: assert property (p_seq_upper) else $error("bad sequence step");

    property p_no_access_nv;
        @(posedge ref_clk) disable iff (rst) (st_q == ST_NVWAIT || st_q == ST_BUSY) |-> ce_q;
    endproperty
    a_no_access_nv: assert property (p_no_access_nv) else $error("access during nv cycle");

    property p_pull_hold;
        @(posedge ref_clk) disable iff (rst) $rose(hpull_q) |-> hpull_q [*8];
    endproperty
    a_pull_hold: assert property (p_pull_hold) else $error("busy pull too short");

    property p_busy_block;
        @(posedge ref_clk) disable iff (rst) (!busy_s2_q) |=> !rdy_q;
    endproperty
    a_busy_block: assert property (p_busy_block) else $error("ready while busy");

    sequence s_seq_next;
        (st_q == ST_SEQ) ##1 (st_q == ST_SETUP);
    endsequence

    property p_seq_b2b;
        @(posedge ref_clk) disable iff (rst) (st_q == ST_END && seq_q && step_q != 3'h5) |=> s_seq_next;
    endproperty
    a_seq_b2b: assert property (p_seq_b2b) else $error("sequence step gap");
endmodule
`default_nettype wire

// ---- sim/nvsc_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvsc_dev_model #(
    parameter int STORE_CYC = 100,
    parameter int RECALL_CYC = 20,
    parameter int PUP_RECALL_CYC = 10,
    parameter int GRACE_CYC = 4
) (
    input wire logic ref_clk,
    input wire logic [16:0] address_lines,
    input wire logic [7:0] data_in,
    input wire logic chip_sel_n,
    input wire logic out_gate_n,
    input wire logic wr_strobe_n,
    input wire logic busy_n,
    output logic [7:0] dev_dq,
    output logic busy_pull
);
    // ----------------------------------------
    // array and state
    // ----------------------------------------
    logic [7:0] mem [int];
    logic [7:0] nv [int];
    logic [15:0] seq [0:4] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F};
    logic [16:0] ra = 17'h00000;
    logic [7:0] wd = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic written = 1'b0;
    logic storing = 1'b0;
    logic rd_on = 1'b0;
    logic wr_on = 1'b0;
    logic hw_seen = 1'b0;
    logic drive;
    int nv_cnt = PUP_RECALL_CYC;
    int grace = 0;
    int step = 0;
    int store_cnt = 0;
    int recall_cnt = 0;
    assign drive = !chip_sel_n && !out_gate_n && wr_strobe_n && (busy_n || grace > 0) && nv_cnt == 0;
    assign dev_dq = drive ? (mem.exists(int'(address_lines)) ? mem[int'(address_lines)] : 8'h00) : ~last_q;
    // ----------------------------------------
    // cycle tracking
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        if (drive)
            last_q <= dev_dq;
        if (wr_on && !(!chip_sel_n && !wr_strobe_n))
        begin
            mem[int'(ra)] = wd;
            written = 1'b1;
            step = 0;
        end
        if (rd_on && !(!chip_sel_n && wr_strobe_n))
        begin
            if (step == 5)
            begin
                storing = ra[15:0] == 16'h8FC0;
                if (storing || ra[15:0] == 16'h4C63)
                    nv_cnt = storing ? STORE_CYC : RECALL_CYC;
                step = 0;
            end
            else
                step = ra[15:0] == seq[step] ? step + 1 : int'(ra[15:0] == seq[0]);
        end
        wr_on = !chip_sel_n && !wr_strobe_n && (wr_on || (busy_n && nv_cnt == 0));
        rd_on = !chip_sel_n && wr_strobe_n && busy_n && nv_cnt == 0;
        if (wr_on)
            wd = data_in;
        if (wr_on || rd_on)
            ra = address_lines;
        if (busy_n)
            hw_seen = 1'b0;
        else if (!hw_seen && nv_cnt == 0)
        begin
            hw_seen = 1'b1;
            grace = GRACE_CYC;
        end
        if (grace > 0)
        begin
            grace--;
            if (grace == 0 && written)
            begin
                storing = 1'b1;
                nv_cnt = STORE_CYC;
            end
        end
        if (nv_cnt == 1)
        begin
            if (storing)
            begin
                nv.delete();
                nv = mem;
                store_cnt++;
            end
            else
            begin
                mem.delete();
                mem = nv;
                recall_cnt++;
            end
            written = 1'b0;
            storing = 1'b0;
        end
        if (nv_cnt > 0)
            nv_cnt--;
        busy_pull <= storing;
    end
endmodule
`default_nettype wire

// ---- sim/nvsc_host_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_tb;
    localparam nvsc_pkg::nvsc_cmd_e RD = nvsc_pkg::NVSC_CMD_READ;
    localparam nvsc_pkg::nvsc_cmd_e WR = nvsc_pkg::NVSC_CMD_WRITE;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    nvsc_pkg::nvsc_cmd_e cmd = RD;
    logic [16:0] cmd_addr = 17'h00000;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_ready, rsp_valid, data_lines_oe, chip_sel_n, out_gate_n, wr_strobe_n;
    logic busy_o, busy_oe, busy_w, busy_pull;
    logic [7:0] rsp_rdata, data_lines_o, data_lines_i, dev_dq, rd;
    logic [16:0] address_lines;
    logic [15:0] sq [0:4] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F};
    int num_errors = 0;
    int compares = 0;
    assign data_lines_i = data_lines_oe ? data_lines_o : dev_dq;
    assign busy_w = !(busy_oe && !busy_o) && !busy_pull;
    nvsc_host #(.STORE_CYC(200), .RECALL_CYC(40), .PUP_RECALL_CYC(20), .GRACE_CYC(10)) nvsc_host_i (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .address_lines(address_lines), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
        .data_lines_i(data_lines_i), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
        .wr_strobe_n(wr_strobe_n), .nv_busy_req_n_o(busy_o), .nv_busy_req_n_oe(busy_oe),
        .nv_busy_req_n_i(busy_w));
    nvsc_dev_model nvsc_dev_model_i (
        .ref_clk(ref_clk), .address_lines(address_lines), .data_in(data_lines_o), .chip_sel_n(chip_sel_n),
        .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .busy_n(busy_w), .dev_dq(dev_dq),
        .busy_pull(busy_pull));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic op(input nvsc_pkg::nvsc_cmd_e c, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 1000)
        begin
            @(negedge ref_clk);
            n++;
        end
        cmd = c;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 2000)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk("op_done", 8'h01, {7'h00, rsp_valid});
        rd = rsp_rdata;
        @(negedge ref_clk);
    endtask
    task automatic rdc(input string n, input logic [16:0] a, input logic [7:0] e);
        op(RD, a, 8'h00);
        chk(n, e, rd);
    endtask
    function automatic logic [7:0] sc();
        return 8'(nvsc_dev_model_i.store_cnt);
    endfunction
    task automatic complete_run();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_hw();
        logic [7:0] s;
        s = sc();
        op(nvsc_pkg::NVSC_CMD_HW_STORE, 17'h00000, 8'h00);
        chk("hw_skip", s, sc());
        op(WR, 17'h1FFFF, 8'hA5);
        op(nvsc_pkg::NVSC_CMD_HW_STORE, 17'h00000, 8'h00);
        chk("hw_store", s + 8'h01, sc());
    endtask
    task automatic t_sw();
        logic [7:0] s;
        s = sc();
        op(nvsc_pkg::NVSC_CMD_SW_STORE, 17'h00000, 8'h00);
        chk("sw_store", s + 8'h01, sc());
        op(WR, 17'h1FFFF, 8'h11);
        rdc("rd_top", 17'h1FFFF, 8'h11);
        s = 8'(nvsc_dev_model_i.recall_cnt);
        op(nvsc_pkg::NVSC_CMD_SW_RECALL, 17'h00000, 8'h00);
        chk("sw_recall", s + 8'h01, 8'(nvsc_dev_model_i.recall_cnt));
        rdc("rd_recalled", 17'h1FFFF, 8'hA5);
    endtask
    task automatic t_seq();
        logic [7:0] s;
        s = sc();
        for (int i = 0; i < 5; i++)
            op(RD, {1'b0, sq[i]}, 8'h00);
        op(WR, 17'h00100, 8'h77);
        op(RD, 17'h08FC0, 8'h00);
        chk("seq_abort", s, sc());
        for (int i = 0; i < 5; i++)
            op(RD, {i == 0, sq[i]}, 8'h00);
        op(RD, 17'h08FC0, 8'h00);
        // plain reads started a store: let it run out
        wait (busy_pull === 1'b1);
        wait (busy_pull === 1'b0);
        @(negedge ref_clk);
        rdc("rd_after_store", 17'h00100, 8'h77);
        chk("seq_high_bit", s + 8'h01, sc());
    endtask
    // ----------------------------------------
    // run
    // ----------------------------------------
    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk)
    begin
        if (!wr_strobe_n)
            chk("gate_in_write", 8'h01, {7'h00, out_gate_n});
        if (busy_pull)
            chk("select_in_store", 8'h01, {7'h00, chip_sel_n});
    end
    initial
    begin
        #2000000;
        num_errors++;
        complete_run();
    end
    initial
    begin
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("ready_in_recall", 8'h00, {7'h00, cmd_ready});
        t_hw();
        t_sw();
        t_seq();
        complete_run();
    end
endmodule
`default_nettype wire
